// File: logic/fps_pkg.sv
// Constants, field layouts and mode codes for the flash pump status block.
// Assumes a single system clock domain; the pump and supply indications
// arrive from analog comparators outside that domain.
// Function
// (R1) Register is nine bits: status 8..6, control 5..0.
// (R2) PROM mode select 101 strobe rise loads 5..0.
// (R3) PROM mode select 101 strobe high drives nine bits.
// (R4) Other modes: ordinary register read and write.
// (R5) Bit 8: erase power and negative threshold.
// (R6) Bit 7: negative pump discharged above minus one.
// (R7) Bit 6: pump running and supply low.
// (R8) Bits 5..4 select negative level under erase.
// (R9) Bits 3..2 reserved, never set.
// (R10) Bits 1..0 select positive program/erase level.
// (R11) Verify enable switches positive level encoding.
// (R12) Reset clears the register to zero.
// (R13) Modes 6 and 7 enter boot programming.
// (R14) Serial boot maps boot ROM at zero.
// (R15) Boot entry sets UART rate for 38400.
// (R16) Boot download uses UART channel 0 only.
// (R17) Boot program lands in RAM 0x08030000..0x08030FFF.
// (R18) Boot start measures host serial low time.
// (R19) Host sends 38400 8N1 at 33.86MHz.
// (R20) Modes 4 and 5 select user program mode.
// (R21) Control software runs from RAM.
// (R22) Host branches, later restores normal mode, resets.
// (R23) Status inputs pass synchronisers before the register.
package fps_pkg;
  // ==========================================================
  // Register layout
  // ==========================================================
  localparam int FPS_REG_W = 9;
  localparam logic [8:0] FPS_RESET_VAL = 9'h000;
  localparam int FPS_BIT_NEG_LVL = 8;
  localparam int FPS_BIT_NEG_DIS = 7;
  localparam int FPS_BIT_SUP_LOW = 6;
  localparam int FPS_NEG_HI = 5;
  localparam int FPS_NEG_LO = 4;
  localparam int FPS_POS_HI = 1;
  localparam int FPS_POS_LO = 0;
  localparam logic [5:0] FPS_CTRL_WMASK = 6'h33;
  localparam logic [2:0] FPS_SEL_PUMP = 3'h5;
  // ==========================================================
  // Operating modes and boot map
  // ==========================================================
  localparam logic [2:0] FPS_MODE_PROM = 3'h1;
  localparam logic [2:0] FPS_MODE_USR_EXT = 3'h4;
  localparam logic [2:0] FPS_MODE_USR_ONE = 3'h5;
  localparam logic [2:0] FPS_MODE_BOOT_EXT = 3'h6;
  localparam logic [2:0] FPS_MODE_BOOT_ONE = 3'h7;
  localparam logic [31:0] FPS_BOOT_ROM_BASE = 32'h0000_0000;
  localparam logic [31:0] FPS_RAM_LO = 32'h0803_0000;
  localparam logic [31:0] FPS_RAM_HI = 32'h0803_0FFF;
  localparam logic [1:0] FPS_BOOT_UART_CH = 2'h0;
  // Bit-rate divisor: operating clock over 16x baud, 33.86 MHz / 38400.
  localparam int FPS_OPCLK_HZ = 33860000;
  localparam int FPS_BAUD = 38400;
  localparam logic [15:0] FPS_BAUD_DIV = 16'((FPS_OPCLK_HZ + 8 * FPS_BAUD) / (16 * FPS_BAUD));
  localparam int FPS_LOWCNT_W = 16;
  // States of the one-shot boot serial low-time measurement.
  typedef enum logic [1:0] {
    FPS_BOOT_IDLE = 2'b00,
    FPS_BOOT_WAIT = 2'b01,
    FPS_BOOT_MEAS = 2'b10,
    FPS_BOOT_DONE = 2'b11
  } fps_boot_t;
endpackage

// File: logic/fps_sync.sv
// Two-flop synchroniser for asynchronous status levels.
// Assumes the inputs are slow levels; a glitch may be lost, which is fine.
`timescale 1ns/10ps
module fps_sync (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [2:0] async_i,
  output logic [2:0] sync_o
);
  logic [2:0] meta_q;
  // ==========================================================
  // Double flop; only the second stage is visible.
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= 3'h0;
      sync_o <= 3'h0;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// File: logic/fps_top.sv
// Pump status and power register with PROM pin access, boot/user mode
// decode and boot serial low-time measurement.
// Assumes mode pins are static around reset and that the PROM writer
// holds select stable across the write strobe edge.
`timescale 1ns/10ps
module fps_top
  import fps_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [2:0] mode_pins_i,
  input wire logic [2:0] register_select_i,
  input wire logic write_strobe_n_i,
  input wire logic [8:0] prom_data_lines_i,
  output logic [8:0] prom_data_lines_o,
  output logic [8:0] prom_data_lines_oe_o,
  input wire logic reg_wr_i,
  input wire logic [8:0] reg_wdata_i,
  output logic [8:0] reg_rdata_o,
  input wire logic erase_power_enable_i,
  input wire logic program_power_enable_i,
  input wire logic verify_enable_i,
  input wire logic neg_pump_below_i,
  input wire logic neg_pump_above_1v_i,
  input wire logic supply_under_i,
  input wire logic uart0_rxd_i,
  output logic [1:0] neg_pump_voltage_sel_o,
  output logic neg_pump_on_o,
  output logic [1:0] pos_pump_voltage_sel_o,
  output logic pos_pump_on_o,
  output logic pos_verify_scale_o,
  output logic serial_boot_select_o,
  output logic boot_ext_bus_o,
  output logic user_prog_mode_o,
  output logic user_ext_bus_o,
  output logic prom_mode_o,
  output logic [31:0] boot_rom_base_o,
  output logic [1:0] boot_uart_ch_o,
  output logic [15:0] uart_baud_div_o,
  output logic uart_baud_load_o,
  output logic [31:0] boot_ram_lo_o,
  output logic [31:0] boot_ram_hi_o,
  output logic [FPS_LOWCNT_W-1:0] low_period_o,
  output logic low_period_valid_o
);
  logic [8:0] pump_status_power_q;
  logic [2:0] stat_sync;
  logic [2:0] mode_q;
  logic strap_taken_q;
  logic [1:0] strobe_s_q;
  logic strobe_prev_q;
  logic [1:0] rxd_s_q;
  logic [2:0] sel_s0_q;
  logic [2:0] sel_s1_q;
  logic [8:0] pd_s0_q;
  logic [8:0] pd_s1_q;
  logic [8:0] pd_hold_q;
  logic prom_wr;
  logic prom_rd;
  fps_boot_t boot_q;
  logic [FPS_LOWCNT_W-1:0] low_cnt_q;

  // Six control bits with the reserved pair forced to zero.
  function automatic logic [5:0] fps_ctrl_mask(input logic [5:0] v);
    fps_ctrl_mask = v & FPS_CTRL_WMASK;
  endfunction

  // ==========================================================
  // Status synchronisers
  // ==========================================================
  // Comparators are analog and asynchronous to the system clock.
  fps_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .async_i({neg_pump_below_i, neg_pump_above_1v_i, supply_under_i}),
    .sync_o(stat_sync)
  ); // see (R23)

  // ==========================================================
  // Mode strap capture
  // ==========================================================
  // Mode pins are caught by a clocked process on the first enabled
  // edge after reset release, never by the asynchronous reset itself.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= 3'h0;
      strap_taken_q <= 1'b0;
    end else if (ce_i && !strap_taken_q) begin
      mode_q <= mode_pins_i;
      strap_taken_q <= 1'b1;
    end
  end

  assign prom_mode_o = strap_taken_q && (mode_q == FPS_MODE_PROM);
  // Modes 6 and 7 are boot programming; 6 keeps the external bus.
  assign serial_boot_select_o = strap_taken_q &&
    (mode_q == FPS_MODE_BOOT_EXT || mode_q == FPS_MODE_BOOT_ONE); // see (R13)
  assign boot_ext_bus_o = strap_taken_q && (mode_q == FPS_MODE_BOOT_EXT); // see (R13)
  assign user_prog_mode_o = strap_taken_q &&
    (mode_q == FPS_MODE_USR_EXT || mode_q == FPS_MODE_USR_ONE); // see (R20)
  assign user_ext_bus_o = strap_taken_q && (mode_q == FPS_MODE_USR_EXT); // see (R20)

  // ==========================================================
  // PROM pin synchronisers and strobe edge detect
  // ==========================================================
  // Pins come from the writer, so all pass two flops first.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_s_q <= 2'b11;
      strobe_prev_q <= 1'b1;
      sel_s0_q <= 3'h0;
      sel_s1_q <= 3'h0;
      pd_s0_q <= 9'h000;
      pd_s1_q <= 9'h000;
      pd_hold_q <= 9'h000;
    end else if (ce_i) begin
      strobe_s_q <= {strobe_s_q[0], write_strobe_n_i};
      strobe_prev_q <= strobe_s_q[1];
      sel_s0_q <= register_select_i;
      sel_s1_q <= sel_s0_q;
      pd_s0_q <= prom_data_lines_i;
      pd_s1_q <= pd_s0_q;
      pd_hold_q <= pd_s1_q;
    end
  end

  // Data is taken one stage later than the strobe so setup on the pins
  // before the rising edge is what lands in the register.
  assign prom_wr = prom_mode_o && (sel_s1_q == FPS_SEL_PUMP) &&
    strobe_s_q[1] && !strobe_prev_q; // see (R2)
  assign prom_rd = prom_mode_o && (sel_s1_q == FPS_SEL_PUMP) && strobe_s_q[1]; // see (R3)

  // ==========================================================
  // Pump status and power register
  // ==========================================================
  // Status bits set from synchronised comparators; software may clear
  // them in normal modes (the writer loads only control bits), but a live set wins over the clear.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_status_power_q <= FPS_RESET_VAL; // see (R12)
    end else if (ce_i) begin
      if (prom_wr) begin
        // Only control bits load; status stays read only here.
        pump_status_power_q[5:0] <= fps_ctrl_mask(pd_hold_q[5:0]); // see (R2) (R9)
      end else if (!prom_mode_o && reg_wr_i) begin
        pump_status_power_q <= {reg_wdata_i[8:6], fps_ctrl_mask(reg_wdata_i[5:0])}; // see (R4) (R9)
      end
      if (erase_power_enable_i && stat_sync[2]) begin
        pump_status_power_q[FPS_BIT_NEG_LVL] <= 1'b1; // see (R5)
      end
      if (stat_sync[1]) begin
        pump_status_power_q[FPS_BIT_NEG_DIS] <= 1'b1; // see (R6)
      end
      if ((program_power_enable_i || erase_power_enable_i) && stat_sync[0]) begin
        pump_status_power_q[FPS_BIT_SUP_LOW] <= 1'b1; // see (R7)
      end
    end
  end

  assign reg_rdata_o = pump_status_power_q; // see (R1) (R4)

  // ==========================================================
  // PROM read drive
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prom_data_lines_o <= 9'h000;
      prom_data_lines_oe_o <= 9'h000;
    end else if (ce_i) begin
      prom_data_lines_o <= pump_status_power_q; // see (R3)
      prom_data_lines_oe_o <= {FPS_REG_W{prom_rd}}; // see (R3)
    end
  end

  // ==========================================================
  // Pump selections
  // ==========================================================
  // Negative select only meaningful under erase power; positive under
  // either power enable or verify enable, with verify switching the level table.
  assign neg_pump_voltage_sel_o = pump_status_power_q[FPS_NEG_HI:FPS_NEG_LO]; // see (R8)
  assign neg_pump_on_o = erase_power_enable_i; // see (R8)
  assign pos_pump_voltage_sel_o = pump_status_power_q[FPS_POS_HI:FPS_POS_LO]; // see (R10)
  assign pos_pump_on_o = program_power_enable_i || erase_power_enable_i ||
    verify_enable_i; // see (R10) (R11)
  assign pos_verify_scale_o = verify_enable_i; // see (R11)

  // ==========================================================
  // Boot map and UART setup
  // ==========================================================
  assign boot_rom_base_o = FPS_BOOT_ROM_BASE; // see (R14)
  assign boot_uart_ch_o = FPS_BOOT_UART_CH; // see (R16)
  assign boot_ram_lo_o = FPS_RAM_LO; // see (R17)
  assign boot_ram_hi_o = FPS_RAM_HI; // see (R17)
  assign uart_baud_div_o = FPS_BAUD_DIV; // see (R15)

  // ==========================================================
  // Boot low-period measurement
  // ==========================================================
  // Receive line is a pin, so it is synchronised before use.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rxd_s_q <= 2'b11;
    end else if (ce_i) begin
      rxd_s_q <= {rxd_s_q[0], uart0_rxd_i};
    end
  end

  // One shot: load the baud divisor, wait for the first low, count it.
  // Counter saturates rather than wrapping on a stuck-low line.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boot_q <= FPS_BOOT_IDLE;
      low_cnt_q <= '0;
      low_period_o <= '0;
      low_period_valid_o <= 1'b0;
      uart_baud_load_o <= 1'b0;
    end else if (ce_i) begin
      uart_baud_load_o <= 1'b0;
      case (boot_q)
        FPS_BOOT_IDLE: begin
          if (serial_boot_select_o) begin
            uart_baud_load_o <= 1'b1; // see (R15)
            boot_q <= FPS_BOOT_WAIT;
          end
        end
        FPS_BOOT_WAIT: begin
          low_cnt_q <= '0;
          if (!rxd_s_q[1]) begin
            boot_q <= FPS_BOOT_MEAS; // see (R18)
          end
        end
        FPS_BOOT_MEAS: begin
          if (rxd_s_q[1]) begin
            low_period_o <= low_cnt_q; // see (R18)
            low_period_valid_o <= 1'b1;
            boot_q <= FPS_BOOT_DONE;
          end else if (low_cnt_q != '1) begin
            low_cnt_q <= low_cnt_q + 1'b1;
          end
        end
        FPS_BOOT_DONE: begin
          boot_q <= FPS_BOOT_DONE;
        end
        default: begin
          boot_q <= FPS_BOOT_IDLE;
        end
      endcase
    end
  end
endmodule

// File: sim/fps_host_model.sv
// Host model on the boot serial line: sends one 8N1 frame per request.
// Assumes send_i is a one-cycle pulse and frames are not overlapped.
`timescale 1ns/10ps
module fps_host_model #(
  parameter int BIT_CYC = 521
) (
  input wire logic clk_sys_i,
  input wire logic send_i,
  input wire logic [7:0] byte_i,
  output logic rxd_o
);
  logic [9:0] frame;
  // The line idles at the mark level between frames, as an async link does.
  // Start bit, eight data bits LSB first, one stop bit, no parity.
  initial begin
    rxd_o = 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (send_i) begin
        frame = {1'b1, byte_i, 1'b0};
        for (int i = 0; i < 10; i++) begin
          rxd_o <= frame[i];
          repeat (BIT_CYC) @(posedge clk_sys_i);
        end
      end
    end
  end
endmodule

// File: sim/fps_properties.sv
// Port-level checks of the pump status register and its PROM read path.
// Assumes one clock domain; bound to every fps_top below.
`timescale 1ns/10ps
module fps_properties (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic [8:0] reg_wdata_i,
  input wire logic [8:0] reg_rdata_o,
  input wire logic erase_power_enable_i,
  input wire logic program_power_enable_i,
  input wire logic neg_pump_below_i,
  input wire logic neg_pump_above_1v_i,
  input wire logic supply_under_i,
  input wire logic [2:0] register_select_i,
  input wire logic write_strobe_n_i,
  input wire logic [8:0] prom_data_lines_oe_o,
  input wire logic prom_mode_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Status levels need three edges: two synchroniser stages, then the bit.
  sequence s_neg_low;
    (ce_i && erase_power_enable_i && neg_pump_below_i)[*3];
  endsequence
  sequence s_pump_read;
    (ce_i && prom_mode_o && register_select_i == 3'h5 && write_strobe_n_i)[*5];
  endsequence
  property p_neg_lvl;
    s_neg_low |=> reg_rdata_o[8];
  endproperty
  a_neg_lvl: assert property (p_neg_lvl) else $error("level flag missed");
  property p_dis;
    (ce_i && neg_pump_above_1v_i)[*3] |=> reg_rdata_o[7];
  endproperty
  a_dis: assert property (p_dis) else $error("discharge flag missed");
  property p_sup;
    (ce_i && supply_under_i && (erase_power_enable_i || program_power_enable_i))[*3]
      |=> reg_rdata_o[6];
  endproperty
  a_sup: assert property (p_sup) else $error("supply flag missed");
  property p_resv;
    reg_rdata_o[3:2] == 2'b00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  // Status bits may be set in the same cycle, so only control bits are compared.
  property p_wr;
    ce_i && reg_wr_i && !prom_mode_o |=> ((reg_rdata_o ^ $past(reg_wdata_i)) & 9'h033) == 0;
  endproperty
  a_wr: assert property (p_wr) else $error("write not taken");
  property p_rst;
    $rose(nrst_i) |-> reg_rdata_o == 9'h000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_prom_rd;
    s_pump_read |-> prom_data_lines_oe_o == 9'h1FF;
  endproperty
  a_prom_rd: assert property (p_prom_rd) else $error("read not driven");
  property p_oe_idle;
    (ce_i && !write_strobe_n_i)[*4] |-> prom_data_lines_oe_o == 9'h000;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pins driven");
endmodule
bind fps_top fps_properties fps_properties_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .erase_power_enable_i(erase_power_enable_i),
  .program_power_enable_i(program_power_enable_i), .neg_pump_below_i(neg_pump_below_i),
  .neg_pump_above_1v_i(neg_pump_above_1v_i), .supply_under_i(supply_under_i),
  .register_select_i(register_select_i), .write_strobe_n_i(write_strobe_n_i),
  .prom_data_lines_oe_o(prom_data_lines_oe_o), .prom_mode_o(prom_mode_o));

// File: sim/fps_tb_top.sv
// Self-checking bench for the pump status register and mode decode.
// Assumes the checker binds itself and the host model is compiled first.
`timescale 1ns/10ps
module flash_pump_status_and_boot_mode_tb_top
  import fps_pkg::*;
;
  // 38400 bps on a 50 ns clock is about 520.8 cycles per bit.
  localparam int BIT_CYC = 521;
  logic clk_sys_i = 1'b0;
  logic nrst_i, ce_i, reg_wr_i, write_strobe_n_i, uart0_rxd_i, send;
  logic erase_power_enable_i, program_power_enable_i, verify_enable_i;
  logic neg_pump_below_i, neg_pump_above_1v_i, supply_under_i;
  logic [2:0] mode_pins_i, register_select_i;
  logic [8:0] prom_data_lines_i, prom_data_lines_o, prom_data_lines_oe_o;
  logic [8:0] reg_wdata_i, reg_rdata_o, pd_drv;
  logic [1:0] neg_pump_voltage_sel_o, pos_pump_voltage_sel_o, boot_uart_ch_o;
  logic neg_pump_on_o, pos_pump_on_o, pos_verify_scale_o, serial_boot_select_o;
  logic boot_ext_bus_o, user_prog_mode_o, user_ext_bus_o, prom_mode_o;
  logic uart_baud_load_o, low_period_valid_o;
  logic [31:0] boot_rom_base_o, boot_ram_lo_o, boot_ram_hi_o;
  logic [15:0] uart_baud_div_o;
  logic [FPS_LOWCNT_W-1:0] low_period_o;
  int err_count = 0;
  int checks = 0;
  int loads = 0;
  // Steps are ordered so a comparator still in the synchroniser never
  // meets a newly raised power enable.
  logic [4:0] st_in [4] = '{5'h01, 5'h02, 5'h14, 5'h09};
  logic [8:0] st_exp [4] = '{9'h021, 9'h0A1, 9'h1A1, 9'h1E1};
  fps_top fps_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .mode_pins_i(mode_pins_i), .register_select_i(register_select_i),
    .write_strobe_n_i(write_strobe_n_i), .prom_data_lines_i(prom_data_lines_i),
    .prom_data_lines_o(prom_data_lines_o), .prom_data_lines_oe_o(prom_data_lines_oe_o),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .erase_power_enable_i(erase_power_enable_i),
    .program_power_enable_i(program_power_enable_i), .verify_enable_i(verify_enable_i),
    .neg_pump_below_i(neg_pump_below_i), .neg_pump_above_1v_i(neg_pump_above_1v_i),
    .supply_under_i(supply_under_i), .uart0_rxd_i(uart0_rxd_i),
    .neg_pump_voltage_sel_o(neg_pump_voltage_sel_o), .neg_pump_on_o(neg_pump_on_o),
    .pos_pump_voltage_sel_o(pos_pump_voltage_sel_o), .pos_pump_on_o(pos_pump_on_o),
    .pos_verify_scale_o(pos_verify_scale_o), .serial_boot_select_o(serial_boot_select_o),
    .boot_ext_bus_o(boot_ext_bus_o), .user_prog_mode_o(user_prog_mode_o),
    .user_ext_bus_o(user_ext_bus_o), .prom_mode_o(prom_mode_o),
    .boot_rom_base_o(boot_rom_base_o), .boot_uart_ch_o(boot_uart_ch_o),
    .uart_baud_div_o(uart_baud_div_o), .uart_baud_load_o(uart_baud_load_o),
    .boot_ram_lo_o(boot_ram_lo_o), .boot_ram_hi_o(boot_ram_hi_o),
    .low_period_o(low_period_o), .low_period_valid_o(low_period_valid_o));
  fps_host_model #(.BIT_CYC(BIT_CYC)) fps_host_model_i (.clk_sys_i(clk_sys_i),
    .send_i(send), .byte_i(8'h00), .rxd_o(uart0_rxd_i));
  // The data pins carry the device's value while it drives them, else ours.
  assign prom_data_lines_i = (prom_data_lines_oe_o & prom_data_lines_o)
    | (~prom_data_lines_oe_o & pd_drv);
  always #25 clk_sys_i = ~clk_sys_i;
  // The load pulse lasts one cycle, so it is counted rather than sampled.
  always @(posedge clk_sys_i) begin
    if (uart_baud_load_o === 1'b1) loads <= loads + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic start(input logic [2:0] mode);
    nrst_i = 1'b0;
    mode_pins_i = mode;
    loads = 0;
    repeat (2) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [8:0] d);
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
    @(negedge clk_sys_i);
  endtask
  // Select and data are held well around the strobe, as the pins are synced.
  task automatic pw(input logic [2:0] sel, input logic [8:0] d);
    register_select_i = sel;
    pd_drv = d;
    write_strobe_n_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    write_strobe_n_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    register_select_i = 3'h0;
    @(negedge clk_sys_i);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence: user, PROM and boot modes in turn.
  initial begin
    {nrst_i, ce_i, reg_wr_i, write_strobe_n_i, send} = 5'b01010;
    {erase_power_enable_i, program_power_enable_i, verify_enable_i} = 3'b000;
    {neg_pump_below_i, neg_pump_above_1v_i, supply_under_i} = 3'b000;
    {mode_pins_i, register_select_i, pd_drv, reg_wdata_i} = '0;
    start(FPS_MODE_USR_ONE);
    chk(reg_rdata_o, 9'h000);
    chk({user_prog_mode_o, user_ext_bus_o, prom_mode_o}, 3'b100);
    wr(9'h1FF);
    chk(reg_rdata_o, 9'h1F3);
    wr(9'h021);
    chk({neg_pump_voltage_sel_o, pos_pump_voltage_sel_o}, 4'b1001);
    for (int i = 0; i < 4; i++) begin
      {erase_power_enable_i, program_power_enable_i, neg_pump_below_i,
        neg_pump_above_1v_i, supply_under_i} = st_in[i];
      repeat (4) @(negedge clk_sys_i);
      chk(reg_rdata_o, st_exp[i]);
    end
    chk({neg_pump_on_o, pos_pump_on_o}, 2'b01);
    {erase_power_enable_i, program_power_enable_i, supply_under_i, verify_enable_i} = 4'b1001;
    repeat (3) @(negedge clk_sys_i);
    chk({neg_pump_on_o, pos_pump_on_o, pos_verify_scale_o}, 3'b111);
    {erase_power_enable_i, verify_enable_i} = 2'b00;
    wr(9'h000);
    chk(reg_rdata_o, 9'h000);
    // A write offered while the clock enable is low must be swallowed.
    ce_i = 1'b0;
    wr(9'h033);
    chk(reg_rdata_o, 9'h000);
    ce_i = 1'b1;
    start(FPS_MODE_USR_EXT);
    chk({user_prog_mode_o, user_ext_bus_o}, 2'b11);
    start(FPS_MODE_PROM);
    wr(9'h033);
    chk({prom_mode_o, reg_rdata_o}, 10'h200);
    pw(3'h5, 9'h1EE);
    chk(reg_rdata_o, 9'h022);
    pw(3'h3, 9'h011);
    register_select_i = 3'h5;
    repeat (5) @(negedge clk_sys_i);
    chk(prom_data_lines_oe_o, 9'h1FF);
    chk(prom_data_lines_i, 9'h022);
    register_select_i = 3'h0;
    start(FPS_MODE_BOOT_ONE);
    chk({serial_boot_select_o, boot_ext_bus_o, boot_uart_ch_o}, 4'b1000);
    chk(boot_rom_base_o, 32'h0000_0000);
    chk({uart_baud_div_o, loads[3:0]}, {16'h0037, 4'h1});
    chk(boot_ram_lo_o, 32'h0803_0000);
    chk(boot_ram_hi_o, 32'h0803_0FFF);
    send = 1'b1;
    @(negedge clk_sys_i);
    send = 1'b0;
    for (int i = 0; i < 6000 && low_period_valid_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk(low_period_valid_o, 1);
    chk(low_period_o >= 9 * BIT_CYC - 2 && low_period_o <= 9 * BIT_CYC + 2, 1);
    start(FPS_MODE_BOOT_EXT);
    chk({serial_boot_select_o, boot_ext_bus_o, user_prog_mode_o}, 3'b110);
    // The host ends a download by strapping a normal mode and resetting.
    start(FPS_MODE_USR_ONE);
    chk({serial_boot_select_o, low_period_valid_o, user_prog_mode_o}, 3'b001);
    summarize();
  end
  // Cuts a hang short; the whole run needs a few thousand cycles.
  initial begin
    #1_000_000;
    err_count++;
    summarize();
  end
endmodule
